// ---- core/filcs_irq_cell.sv ----
`timescale 1ns/1ns
module filcs_irq_cell (
    // Clock and reset
    input wire logic clk_in,
    input wire logic rst_in,
    // Status side
    input wire logic event_in,
    input wire logic rd_clr_in,
    input wire logic wr_clr_in,
    // Enable side
    input wire logic en_wr_in,
    input wire logic en_wdata_in,
    input wire logic en_auto_clr_in,
    // State
    output logic status_out,
    output logic enable_out
);
    logic status_ff;
    logic enable_ff;

    // Sticky status; a new event beats any clear
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            status_ff <= 1'b0;
        end else if (event_in) begin
            status_ff <= 1'b1;
        end else if (rd_clr_in || wr_clr_in) begin
            status_ff <= 1'b0;
        end
    end

    // Enable bit, cleared by a status read when auto clear is on
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            enable_ff <= 1'b0;
        end else if (en_wr_in) begin
            enable_ff <= en_wdata_in;
        end else if (en_auto_clr_in) begin
            enable_ff <= 1'b0;
        end
    end

    assign status_out = status_ff;
    assign enable_out = enable_ff;
endmodule // filcs_irq_cell

// ---- core/filcs_link_if.sv ----
`timescale 1ns/1ns
// Control and data between register core and one link transmitter
interface filcs_link_if;
    logic enable;
    logic mode;
    logic msg_active;
    logic msg_bit;
    logic tx_bit;
    logic abort_pulse;

    modport core (
        output enable,
        output mode,
        output msg_active,
        output msg_bit,
        input tx_bit,
        input abort_pulse
    );

    modport tx (
        input enable,
        input mode,
        input msg_active,
        input msg_bit,
        output tx_bit,
        output abort_pulse
    );
endinterface // filcs_link_if

// ---- core/filcs_link_tx.sv ----
`timescale 1ns/1ns
module filcs_link_tx (
    // Clock and reset
    input wire logic clk_in,
    input wire logic rst_in,
    // Link side
    filcs_link_if.tx link
);
    filcs_pkg::filcs_tx_state_e state_ff;
    filcs_pkg::filcs_tx_state_e nxt_state;
    logic [filcs_pkg::FLAG_IDX_W-1:0] flag_idx_ff;
    logic [filcs_pkg::FLAG_IDX_W-1:0] nxt_flag_idx;
    logic tx_bit_ff;
    logic nxt_tx_bit;
    logic abort_ff;

    // Disabled controller sends ones or idle flags by mode
    always_comb begin
        if (link.enable) begin
            nxt_state = filcs_pkg::FILCS_TX_DATA;
        end else if (link.mode == filcs_pkg::MODE_MSG_ORIENTED) begin
            nxt_state = filcs_pkg::FILCS_TX_FLAG;
        end else begin
            nxt_state = filcs_pkg::FILCS_TX_ONES;
        end
    end

    // Flag bit position restarts on entry to flag state
    always_comb begin
        if (state_ff == filcs_pkg::FILCS_TX_FLAG) begin
            nxt_flag_idx = flag_idx_ff + 3'h1;
        end else begin
            nxt_flag_idx = 3'h0;
        end
    end

    // Line bit per state
    always_comb begin
        unique case (nxt_state)
            filcs_pkg::FILCS_TX_DATA: nxt_tx_bit = link.msg_bit;
            filcs_pkg::FILCS_TX_ONES: nxt_tx_bit = 1'b1;
            filcs_pkg::FILCS_TX_FLAG: nxt_tx_bit = filcs_pkg::IDLE_FLAG[nxt_flag_idx];
        endcase
    end

    // State, flag position and line bit
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            state_ff <= filcs_pkg::FILCS_TX_DATA;
            flag_idx_ff <= 3'h0;
            tx_bit_ff <= 1'b1;
        end else begin
            state_ff <= nxt_state;
            flag_idx_ff <= nxt_flag_idx;
            tx_bit_ff <= nxt_tx_bit;
        end
    end

    // Pulse when a message in flight is cut off
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            abort_ff <= 1'b0;
        end else begin
            abort_ff <= (state_ff == filcs_pkg::FILCS_TX_DATA) && !link.enable
                && link.msg_active;
        end
    end

    assign link.tx_bit = tx_bit_ff;
    assign link.abort_pulse = abort_ff;
endmodule // filcs_link_tx

// ---- core/filcs_pkg.sv ----
package filcs_pkg;

    // Bus geometry
    localparam int ADDR_W = 9;
    localparam int DATA_W = 32;
    localparam int REG_W = 8;

    // Event sources and link controllers
    localparam int NUM_EXT_EVT = 5;
    localparam int NUM_LINK = 3;
    localparam int NUM_EVT = NUM_EXT_EVT + NUM_LINK;

    // Register indices; byte address is four times the index
    localparam logic [ADDR_W-1:0] IDX_IRQ_STATUS = 9'h118;
    localparam logic [ADDR_W-1:0] IDX_IRQ_ENABLE = 9'h119;
    localparam logic [ADDR_W-1:0] IDX_IRQ_CTRL = 9'h11A;
    localparam logic [ADDR_W-1:0] IDX_LINK_SEL = 9'h11B;

    // Interrupt control fields
    localparam int CTL_CLR_MODE_BIT = 2;
    localparam int CTL_ENB_CLR_BIT = 1;
    localparam int CTL_BLK_EN_BIT = 0;
    localparam logic [REG_W-1:0] CTL_MASK = 8'h07;
    localparam logic [REG_W-1:0] CTL_RST = 8'h00;

    // Link controller select fields
    localparam int LSR_EN_LSB = 2;
    localparam int LSR_SEL_LSB = 0;
    localparam int SEL_W = 2;
    localparam logic [REG_W-1:0] LSR_MASK = 8'h1F;
    localparam logic [REG_W-1:0] LSR_RST = 8'h1C;

    // Interrupt status and enable reset values
    localparam logic [NUM_EVT-1:0] IRQ_STATUS_RST = 8'h00;
    localparam logic [NUM_EVT-1:0] IRQ_ENABLE_RST = 8'h00;

    // Controller select codes
    localparam logic [SEL_W-1:0] SEL_CTRL1_A = 2'h0;
    localparam logic [SEL_W-1:0] SEL_CTRL2 = 2'h1;
    localparam logic [SEL_W-1:0] SEL_CTRL3 = 2'h2;
    localparam logic [SEL_W-1:0] SEL_CTRL1_B = 2'h3;
    localparam logic [NUM_LINK-1:0] ONEHOT_CTRL1 = 3'h1;
    localparam logic [NUM_LINK-1:0] ONEHOT_CTRL2 = 3'h2;
    localparam logic [NUM_LINK-1:0] ONEHOT_CTRL3 = 3'h4;

    // Link transmit modes and idle flag
    localparam logic MODE_BIT_ORIENTED = 1'b0;
    localparam logic MODE_MSG_ORIENTED = 1'b1;
    localparam logic [7:0] IDLE_FLAG = 8'h7E;
    localparam int FLAG_IDX_W = 3;

    typedef enum logic [1:0] {
        FILCS_TX_DATA,
        FILCS_TX_ONES,
        FILCS_TX_FLAG
    } filcs_tx_state_e;

endpackage

// ---- core/filcs_regs.sv ----
`timescale 1ns/1ns
module filcs_regs (
    // Clock and reset
    input wire logic mclk_in,
    input wire logic reset_in,
    // Avalon-MM slave
    input wire logic [filcs_pkg::ADDR_W-1:0] avs_address_in,
    input wire logic avs_read_in,
    input wire logic avs_write_in,
    input wire logic [filcs_pkg::DATA_W-1:0] avs_writedata_in,
    input wire logic [3:0] avs_byteenable_in,
    output logic [filcs_pkg::DATA_W-1:0] avs_readdata_out,
    output logic avs_waitrequest_out,
    // Framer status events
    input wire logic [filcs_pkg::NUM_EXT_EVT-1:0] event_in,
    // Link controller message side
    input wire logic [filcs_pkg::NUM_LINK-1:0] link_mode_in,
    input wire logic [filcs_pkg::NUM_LINK-1:0] link_msg_active_in,
    input wire logic [filcs_pkg::NUM_LINK-1:0] link_msg_bit_in,
    // Link controller outputs
    output logic [filcs_pkg::NUM_LINK-1:0] link_tx_bit_out,
    output logic [filcs_pkg::NUM_LINK-1:0] link_enable_out,
    output logic [filcs_pkg::NUM_LINK-1:0] link_select_out,
    // Interrupt
    output logic irq_out
);
    // Bus handshake
    logic wait_ff;
    logic nxt_wait;
    logic req_new;
    logic req_done;
    logic wr_done;
    logic rd_done;
    logic [filcs_pkg::DATA_W-1:0] rdata_ff;
    logic [filcs_pkg::DATA_W-1:0] nxt_rdata;

    // Register strobes
    logic wr_status;
    logic wr_enable;
    logic wr_ctrl;
    logic wr_sel;
    logic rd_status_new;
    logic rd_status_done;

    // Zero-filled read words
    logic [filcs_pkg::DATA_W-1:0] rword_status;
    logic [filcs_pkg::DATA_W-1:0] rword_enable;
    logic [filcs_pkg::DATA_W-1:0] rword_ctrl;
    logic [filcs_pkg::DATA_W-1:0] rword_sel;

    // Address decode
    logic hit_status;
    logic hit_enable;
    logic hit_ctrl;
    logic hit_sel;
    logic lane0;

    // Registers
    logic [filcs_pkg::REG_W-1:0] ctl_reg_ff;
    logic [filcs_pkg::REG_W-1:0] lsr_ff;
    logic [filcs_pkg::NUM_LINK-1:0] sel_onehot_ff;
    logic [filcs_pkg::NUM_LINK-1:0] nxt_sel_onehot;
    logic irq_ff;

    // Control fields
    logic clr_on_write;
    logic enb_auto_clr;
    logic blk_irq_en;
    logic [filcs_pkg::SEL_W-1:0] sel_code;

    // Interrupt cells
    logic [filcs_pkg::NUM_EVT-1:0] evt_all;
    logic [filcs_pkg::NUM_EVT-1:0] status_vec;
    logic [filcs_pkg::NUM_EVT-1:0] enable_vec;
    logic [filcs_pkg::NUM_EVT-1:0] rd_seen_ff;
    logic [filcs_pkg::NUM_EVT-1:0] rd_clr_vec;
    logic [filcs_pkg::NUM_EVT-1:0] wr_clr_vec;
    logic [filcs_pkg::NUM_EVT-1:0] en_auto_vec;
    logic [filcs_pkg::NUM_EVT-1:0] wdata_evt;
    logic [filcs_pkg::NUM_LINK-1:0] abort_vec;
    logic [filcs_pkg::NUM_LINK-1:0] tx_bit_vec;
    logic [filcs_pkg::NUM_EVT-1:0] pend_vec;

    // Field extraction
    assign clr_on_write = ctl_reg_ff[filcs_pkg::CTL_CLR_MODE_BIT];
    assign enb_auto_clr = ctl_reg_ff[filcs_pkg::CTL_ENB_CLR_BIT];
    assign blk_irq_en = ctl_reg_ff[filcs_pkg::CTL_BLK_EN_BIT];
    assign sel_code = lsr_ff[filcs_pkg::LSR_SEL_LSB +: filcs_pkg::SEL_W];

    // Request phases: new request, then accepted one cycle later
    assign req_new = (avs_read_in || avs_write_in) && wait_ff;
    assign req_done = (avs_read_in || avs_write_in) && !wait_ff;
    assign wr_done = req_done && avs_write_in;
    assign rd_done = req_done && avs_read_in;
    assign lane0 = avs_byteenable_in[0];

    // Decode
    assign hit_status = (avs_address_in == filcs_pkg::IDX_IRQ_STATUS);
    assign hit_enable = (avs_address_in == filcs_pkg::IDX_IRQ_ENABLE);
    assign hit_ctrl = (avs_address_in == filcs_pkg::IDX_IRQ_CTRL);
    assign hit_sel = (avs_address_in == filcs_pkg::IDX_LINK_SEL);

    // Per-register strobes; lane 0 carries every register
    assign wr_status = wr_done && hit_status && lane0;
    assign wr_enable = wr_done && hit_enable && lane0;
    assign wr_ctrl = wr_done && hit_ctrl && lane0;
    assign wr_sel = wr_done && hit_sel && lane0;
    assign rd_status_new = req_new && avs_read_in && hit_status;
    assign rd_status_done = rd_done && hit_status;

    // Waitrequest drops for exactly one cycle per request
    assign nxt_wait = !req_new;

    // Wait state register
    always_ff @(posedge mclk_in or posedge reset_in) begin
        if (reset_in) begin
            wait_ff <= 1'b1;
        end else begin
            wait_ff <= nxt_wait;
        end
    end

    // Read words; bits above each register read zero
    always_comb begin
        rword_status = '0;
        rword_enable = '0;
        rword_ctrl = '0;
        rword_sel = '0;
        rword_status[filcs_pkg::NUM_EVT-1:0] = status_vec;
        rword_enable[filcs_pkg::NUM_EVT-1:0] = enable_vec;
        rword_ctrl[filcs_pkg::REG_W-1:0] = ctl_reg_ff & filcs_pkg::CTL_MASK;
        rword_sel[filcs_pkg::REG_W-1:0] = lsr_ff & filcs_pkg::LSR_MASK;
    end

    // Read data mux; unmapped indices read zero
    always_comb begin
        nxt_rdata = '0;
        if (hit_status) begin
            nxt_rdata = rword_status;
        end else if (hit_enable) begin
            nxt_rdata = rword_enable;
        end else if (hit_ctrl) begin
            nxt_rdata = rword_ctrl;
        end else if (hit_sel) begin
            nxt_rdata = rword_sel;
        end
    end

    // Read data captured at request, held until the next read
    always_ff @(posedge mclk_in or posedge reset_in) begin
        if (reset_in) begin
            rdata_ff <= '0;
        end else if (req_new && avs_read_in) begin
            rdata_ff <= nxt_rdata;
        end
    end

    // Status bits the pending read has shown to software
    always_ff @(posedge mclk_in or posedge reset_in) begin
        if (reset_in) begin
            rd_seen_ff <= '0;
        end else if (rd_status_new) begin
            rd_seen_ff <= status_vec;
        end
    end

    // Interrupt control register; reserved bits dropped
    always_ff @(posedge mclk_in or posedge reset_in) begin
        if (reset_in) begin
            ctl_reg_ff <= filcs_pkg::CTL_RST;
        end else if (wr_ctrl) begin
            ctl_reg_ff <= avs_writedata_in[filcs_pkg::REG_W-1:0] & filcs_pkg::CTL_MASK;
        end
    end

    // Link select register; enables come up set
    always_ff @(posedge mclk_in or posedge reset_in) begin
        if (reset_in) begin
            lsr_ff <= filcs_pkg::LSR_RST;
        end else if (wr_sel) begin
            lsr_ff <= avs_writedata_in[filcs_pkg::REG_W-1:0] & filcs_pkg::LSR_MASK;
        end
    end

    // Select code to one-hot controller
    always_comb begin
        unique case (sel_code)
            filcs_pkg::SEL_CTRL1_A: nxt_sel_onehot = filcs_pkg::ONEHOT_CTRL1;
            filcs_pkg::SEL_CTRL2: nxt_sel_onehot = filcs_pkg::ONEHOT_CTRL2;
            filcs_pkg::SEL_CTRL3: nxt_sel_onehot = filcs_pkg::ONEHOT_CTRL3;
            filcs_pkg::SEL_CTRL1_B: nxt_sel_onehot = filcs_pkg::ONEHOT_CTRL1;
        endcase
    end

    // Registered select keeps the output off the decode
    always_ff @(posedge mclk_in or posedge reset_in) begin
        if (reset_in) begin
            sel_onehot_ff <= filcs_pkg::ONEHOT_CTRL1;
        end else begin
            sel_onehot_ff <= nxt_sel_onehot;
        end
    end

    // Event vector: external sources low, link aborts high
    assign evt_all = {abort_vec, event_in};

    // Write data as seen by the event bits
    assign wdata_evt = avs_writedata_in[filcs_pkg::NUM_EVT-1:0];

    // Pending interrupts: status gated by enables
    assign pend_vec = status_vec & enable_vec;

    // Mode 0: a status read drops the bits it showed
    always_comb begin
        rd_clr_vec = '0;
        if (rd_status_done && !clr_on_write) begin
            rd_clr_vec = rd_seen_ff;
        end
    end

    // Auto clear: a status read drops enables of bits shown set
    always_comb begin
        en_auto_vec = '0;
        if (rd_status_done && enb_auto_clr) begin
            en_auto_vec = rd_seen_ff;
        end
    end

    // Mode 1: written ones drop status bits
    always_comb begin
        wr_clr_vec = '0;
        if (wr_status && clr_on_write) begin
            wr_clr_vec = wdata_evt;
        end
    end

    // One status/enable cell per event
    for (genvar i = 0; i < filcs_pkg::NUM_EVT; i++) begin : g_irq
        filcs_irq_cell u_cell (
            .clk_in(mclk_in),
            .rst_in(reset_in),
            .event_in(evt_all[i]),
            .rd_clr_in(rd_clr_vec[i]),
            .wr_clr_in(wr_clr_vec[i]),
            .en_wr_in(wr_enable),
            .en_wdata_in(wdata_evt[i]),
            .en_auto_clr_in(en_auto_vec[i]),
            .status_out(status_vec[i]),
            .enable_out(enable_vec[i])
        );
    end

    // One transmitter per link controller
    for (genvar k = 0; k < filcs_pkg::NUM_LINK; k++) begin : g_link
        filcs_link_if u_if ();

        assign u_if.enable = lsr_ff[filcs_pkg::LSR_EN_LSB + k];
        assign u_if.mode = link_mode_in[k];
        assign u_if.msg_active = link_msg_active_in[k];
        assign u_if.msg_bit = link_msg_bit_in[k];
        assign tx_bit_vec[k] = u_if.tx_bit;
        assign abort_vec[k] = u_if.abort_pulse;

        filcs_link_tx u_tx (
            .clk_in(mclk_in),
            .rst_in(reset_in),
            .link(u_if.tx)
        );
    end

    // Interrupt level gated by block enable
    always_ff @(posedge mclk_in or posedge reset_in) begin
        if (reset_in) begin
            irq_ff <= 1'b0;
        end else begin
            irq_ff <= blk_irq_en && |pend_vec;
        end
    end

    // Bus outputs
    assign avs_readdata_out = rdata_ff;
    assign avs_waitrequest_out = wait_ff;

    // Link and interrupt outputs
    assign link_tx_bit_out = tx_bit_vec;
    assign link_enable_out = lsr_ff[filcs_pkg::LSR_EN_LSB +: filcs_pkg::NUM_LINK];
    assign link_select_out = sel_onehot_ff;
    assign irq_out = irq_ff;
endmodule // filcs_regs

// ---- tb/filcs_regs_properties.sv ----
`timescale 1ns/1ns
module filcs_regs_properties (
    // Clock, reset and bus
    input wire logic mclk_in,
    input wire logic reset_in,
    input wire logic [filcs_pkg::ADDR_W-1:0] avs_address_in,
    input wire logic avs_read_in,
    input wire logic avs_write_in,
    input wire logic [filcs_pkg::DATA_W-1:0] avs_writedata_in,
    input wire logic [3:0] avs_byteenable_in,
    input wire logic [filcs_pkg::DATA_W-1:0] avs_readdata_out,
    input wire logic avs_waitrequest_out,
    // Link and interrupt
    input wire logic [2:0] link_mode_in,
    input wire logic [2:0] link_msg_bit_in,
    input wire logic [2:0] link_tx_bit_out,
    input wire logic [2:0] link_enable_out,
    input wire logic [2:0] link_select_out,
    input wire logic irq_out
);
    logic [7:0] ctl_ff;
    logic [7:0] sel_ff;
    logic wr_done;
    logic rd_done;
    logic [2:0] sel_exp;
    default clocking @(posedge mclk_in); endclocking
    default disable iff (reset_in);
    // Completed bus transfers
    assign wr_done = avs_write_in && !avs_waitrequest_out && avs_byteenable_in[0];
    assign rd_done = avs_read_in && !avs_waitrequest_out;
    // One-hot controller expected from select code
    always_comb begin
        case (sel_ff[1:0])
            2'h1: sel_exp = 3'h2;
            2'h2: sel_exp = 3'h4;
            default: sel_exp = 3'h1;
        endcase
    end
    // Shadow copies of the two control registers
    always_ff @(posedge mclk_in or posedge reset_in) begin
        if (reset_in) begin
            ctl_ff <= filcs_pkg::CTL_RST;
            sel_ff <= filcs_pkg::LSR_RST;
        end else if (wr_done && avs_address_in == filcs_pkg::IDX_IRQ_CTRL) begin
            ctl_ff <= avs_writedata_in[7:0] & filcs_pkg::CTL_MASK;
        end else if (wr_done && avs_address_in == filcs_pkg::IDX_LINK_SEL) begin
            sel_ff <= avs_writedata_in[7:0] & filcs_pkg::LSR_MASK;
        end
    end
    a_wait_answer: assert property ((avs_read_in || avs_write_in) && avs_waitrequest_out
        |=> !avs_waitrequest_out) else $error("request not answered next cycle");
    a_wait_single: assert property (!avs_waitrequest_out |=> avs_waitrequest_out)
        else $error("waitrequest low two cycles");
    a_rsvd_zero: assert property (
        rd_done |-> avs_readdata_out[31:8] == 24'h0) else $error("upper read bits set");
    a_ctrl_readback: assert property (
        rd_done && avs_address_in == filcs_pkg::IDX_IRQ_CTRL |-> avs_readdata_out[7:0] == ctl_ff)
        else $error("control readback wrong");
    a_sel_readback: assert property (
        rd_done && avs_address_in == filcs_pkg::IDX_LINK_SEL |-> avs_readdata_out[7:0] == sel_ff)
        else $error("select readback wrong");
    a_enable_follow: assert property (link_enable_out == sel_ff[4:2])
        else $error("link enables differ from register");
    a_select_decode: assert property (link_select_out == $past(sel_exp))
        else $error("selected controller wrong");
    a_tx_ones: assert property (!$past(reset_in) |->
        ($past(~link_enable_out & ~link_mode_in) & ~link_tx_bit_out) == 3'h0)
        else $error("disabled bit-oriented line not ones");
    a_tx_pass: assert property (!$past(reset_in) |->
        ($past(link_enable_out) & (link_tx_bit_out ^ $past(link_msg_bit_in))) == 3'h0)
        else $error("enabled line not passing message bit");
    a_irq_gate: assert property (irq_out |-> $past(ctl_ff[0]))
        else $error("interrupt with block disabled");
    c_irq: cover property ($rose(irq_out));
    c_disable: cover property ($fell(link_enable_out[1]));
    c_status_rd: cover property (rd_done && avs_address_in == filcs_pkg::IDX_IRQ_STATUS);
endmodule // filcs_regs_properties

bind filcs_regs filcs_regs_properties u_props (
    .mclk_in, .reset_in, .avs_address_in, .avs_read_in, .avs_write_in, .avs_writedata_in,
    .avs_byteenable_in, .avs_readdata_out, .avs_waitrequest_out, .link_mode_in,
    .link_msg_bit_in, .link_tx_bit_out, .link_enable_out, .link_select_out, .irq_out
);

// ---- tb/filcs_regs_tb.sv ----
`timescale 1ns/1ns
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin n_mismatch++; \
    $display("unexpected at %0t: got %0h expected %0h", $time, a, b); end end
module filcs_regs_tb;
    typedef struct {logic [8:0] a; logic [7:0] w; logic [7:0] r; logic [2:0] s;} filcs_row_s;
    localparam logic [8:0] STA = filcs_pkg::IDX_IRQ_STATUS;
    localparam logic [8:0] ENA = filcs_pkg::IDX_IRQ_ENABLE;
    localparam logic [8:0] CTL = filcs_pkg::IDX_IRQ_CTRL;
    localparam logic [8:0] SEL = filcs_pkg::IDX_LINK_SEL;
    logic mclk_in;
    logic reset_in;
    logic [8:0] avs_address_in;
    logic avs_read_in;
    logic avs_write_in;
    logic [31:0] avs_writedata_in;
    logic [3:0] avs_byteenable_in;
    logic [31:0] avs_readdata_out;
    logic avs_waitrequest_out;
    logic [4:0] event_in;
    logic [2:0] link_mode_in;
    logic [2:0] link_msg_active_in;
    logic [2:0] link_msg_bit_in;
    logic [2:0] link_tx_bit_out;
    logic [2:0] link_enable_out;
    logic [2:0] link_select_out;
    logic irq_out;
    logic [31:0] d;
    int n_mismatch;
    int compares;
    logic [31:0] rst_exp [4] = '{32'h0, 32'h0, 32'h0, 32'h1C};
    filcs_row_s rows [8] = '{'{CTL, 8'hFF, 8'h07, 3'h1}, '{CTL, 8'h00, 8'h00, 3'h1},
        '{9'h000, 8'hFF, 8'h00, 3'h1}, '{SEL, 8'hFF, 8'h1F, 3'h1},
        '{SEL, 8'h1D, 8'h1D, 3'h2}, '{SEL, 8'h1E, 8'h1E, 3'h4},
        '{SEL, 8'h00, 8'h00, 3'h1}, '{SEL, 8'h1C, 8'h1C, 3'h1}};

    filcs_regs DUT (
        .mclk_in, .reset_in, .avs_address_in, .avs_read_in, .avs_write_in,
        .avs_writedata_in, .avs_byteenable_in, .avs_readdata_out, .avs_waitrequest_out,
        .event_in, .link_mode_in, .link_msg_active_in, .link_msg_bit_in,
        .link_tx_bit_out, .link_enable_out, .link_select_out, .irq_out
    );

    // Clock generator
    initial begin
        mclk_in = 1'b0;
        forever #10 mclk_in = ~mclk_in;
    end

    // One bus transfer, held until waitrequest is seen low
    task automatic xfer(input logic w, input logic [8:0] a, input logic [7:0] v);
        int i = 0;
        @(posedge mclk_in);
        avs_address_in <= a;
        avs_writedata_in <= {24'h0, v};
        avs_write_in <= w;
        avs_read_in <= !w;
        do begin
            @(posedge mclk_in);
            i++;
        end while (avs_waitrequest_out !== 1'b0 && i < 20);
        if (i >= 20) n_mismatch++;
        d = avs_readdata_out;
        avs_write_in <= 1'b0;
        avs_read_in <= 1'b0;
    endtask

    // Wait edges, then let outputs settle
    task automatic tick(input int n);
        repeat (n) @(posedge mclk_in);
        #1;
    endtask

    // One-cycle framer event
    task automatic pulse(input logic [4:0] v);
        @(posedge mclk_in);
        event_in <= v;
        @(posedge mclk_in);
        event_in <= 5'h00;
    endtask

    // Counts and verdict
    task automatic results;
        $display("mismatches %0d compares %0d", n_mismatch, compares);
        if (n_mismatch == 0 && compares > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // Watchdog against a hung handshake
    initial begin
        #100000;
        n_mismatch++;
        results();
    end

    // Main sequence
    initial begin
        n_mismatch = 0;
        compares = 0;
        reset_in = 1'b1;
        avs_address_in = 9'h000;
        avs_read_in = 1'b0;
        avs_write_in = 1'b0;
        avs_writedata_in = 32'h0;
        avs_byteenable_in = 4'hF;
        event_in = 5'h00;
        link_mode_in = 3'h0;
        link_msg_active_in = 3'h0;
        link_msg_bit_in = 3'h0;
        repeat (8) @(posedge mclk_in);
        reset_in <= 1'b0;
        foreach (rows[k]) begin
            xfer(1'b1, rows[k].a, rows[k].w);
            xfer(1'b0, rows[k].a, 8'h00);
            `CHK(d, {24'h0, rows[k].r})
            `CHK(link_select_out, rows[k].s)
            if (rows[k].a == SEL) `CHK(link_enable_out, rows[k].r[4:2])
        end
        $display("register table done");
        // Clear on read, enables kept
        xfer(1'b1, CTL, 8'h01);
        xfer(1'b1, ENA, 8'h01);
        pulse(5'h01);
        tick(3);
        `CHK(irq_out, 1'b1)
        xfer(1'b0, STA, 8'h00);
        `CHK(d, 32'h01)
        xfer(1'b0, STA, 8'h00);
        `CHK(d, 32'h00)
        xfer(1'b0, ENA, 8'h00);
        `CHK(d, 32'h01)
        #1 `CHK(irq_out, 1'b0)
        $display("clear on read done");
        // Clear on write, enables auto cleared
        xfer(1'b1, CTL, 8'h07);
        xfer(1'b1, ENA, 8'h03);
        pulse(5'h02);
        xfer(1'b0, STA, 8'h00);
        `CHK(d, 32'h02)
        xfer(1'b0, STA, 8'h00);
        `CHK(d, 32'h02)
        xfer(1'b0, ENA, 8'h00);
        `CHK(d, 32'h01)
        #1 `CHK(irq_out, 1'b0)
        xfer(1'b1, STA, 8'h02);
        xfer(1'b0, STA, 8'h00);
        `CHK(d, 32'h00)
        $display("clear on write done");
        // Block enable gating and ignored byte lane
        xfer(1'b1, CTL, 8'h04);
        pulse(5'h01);
        tick(3);
        `CHK(irq_out, 1'b0)
        xfer(1'b1, ENA, 8'h01);
        avs_byteenable_in <= 4'h0;
        xfer(1'b1, CTL, 8'h00);
        avs_byteenable_in <= 4'hF;
        xfer(1'b0, CTL, 8'h00);
        `CHK(d, 32'h04)
        xfer(1'b1, CTL, 8'h05);
        tick(2);
        `CHK(irq_out, 1'b1)
        xfer(1'b1, STA, 8'h01);
        tick(2);
        `CHK(irq_out, 1'b0)
        $display("block enable done");
        // Bit-oriented controller disabled mid-message
        @(posedge mclk_in);
        link_mode_in <= 3'h2;
        link_msg_active_in <= 3'h7;
        xfer(1'b1, SEL, 8'h18);
        tick(2);
        repeat (8) begin
            `CHK(link_tx_bit_out[0], 1'b1)
            tick(1);
        end
        xfer(1'b0, STA, 8'h00);
        `CHK(d, 32'h20)
        // Message-oriented controller disabled mid-message
        xfer(1'b1, SEL, 8'h10);
        for (int i = 0; i < 16; i++) begin
            @(posedge mclk_in);
            link_msg_bit_in <= ~link_msg_bit_in;
            #1 `CHK(link_tx_bit_out[1], filcs_pkg::IDLE_FLAG[i % 8])
        end
        xfer(1'b0, STA, 8'h00);
        `CHK(d, 32'h60)
        $display("link disable done");
        // Reset in mid-run
        reset_in <= 1'b1;
        tick(2);
        `CHK(link_enable_out, 3'h7)
        `CHK(link_select_out, 3'h1)
        `CHK(irq_out, 1'b0)
        @(posedge mclk_in);
        reset_in <= 1'b0;
        foreach (rst_exp[k]) begin
            xfer(1'b0, STA + 9'(k), 8'h00);
            `CHK(d, rst_exp[k])
        end
        $display("reset values done");
        results();
    end
endmodule // filcs_regs_tb
